/* rtl/lsfs_pkg.sv */
package lsfs_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int POR_NS = 100_000;
    localparam int POR_CYC = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BLANK_NS = 7000;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int HOLD_MS = 8;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int NSTR = 4;
    localparam logic [7:0] OFS_STR_LO = 8'h05;
    localparam logic [7:0] OFS_STR_HI = 8'h06;
    localparam logic [7:0] OFS_CHIP = 8'h07;
    localparam logic [7:0] STAT_RST = 8'h00;
    // String status fields, per string of a pair
    localparam int SB_UNUSED = 0;
    localparam int SB_OPEN = 1;
    localparam int SB_OV = 2;
    localparam int SB_STRIDE = 3;
    // Chip fault status fields
    localparam int CB_WARN = 0;
    localparam int CB_OTP = 1;
    localparam int CB_OC = 2;
    localparam int CB_OCS = 3;
endpackage : lsfs_pkg

/* rtl/lsfs_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Register read path between serial slave and status logic
interface lsfs_reg_if;
    logic [7:0] ptr;   // Register pointer
    logic [7:0] rdata; // Data of pointed register
    logic rd_stb;      // One-cycle pulse: byte taken for reading
    modport slave (output ptr, output rd_stb, input rdata);
    modport regs (input ptr, input rd_stb, output rdata);
endinterface : lsfs_reg_if
`default_nettype wire

/* rtl/lsfs_tmr.sv */
`timescale 1ns/1ps
`default_nettype none
// Retriggerable one-shot: busy for CYC cycles after the last load
module lsfs_tmr #(
    parameter int CYC = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    output logic busy
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt_q; // Remaining cycles

    if (CYC < 1) begin : g_chk
        $error("lsfs_tmr: CYC must be at least 1");
    end

    // Load restarts, otherwise count down to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= W'(CYC);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
endmodule : lsfs_tmr
`default_nettype wire

/* rtl/lsfs_i2c.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-wire slave: pointer write, then byte reads from the pointer
module lsfs_i2c #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    lsfs_reg_if.slave rif
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACKA = 7'h04, S_WR = 7'h08,
        S_ACKW = 7'h10, S_RD = 7'h20, S_ACKR = 7'h40
    } lsfs_i2c_st_t;
    lsfs_i2c_st_t st_q;
    logic scl_p_q, sda_p_q, mack_q, stb_q;
    logic [3:0] cnt_q;  // Bits taken in this byte
    logic [7:0] sh_q;   // Shift register
    logic [7:0] ptr_q;  // Register pointer

    // Line events
    wire rise = scl & ~scl_p_q;
    wire fall = ~scl & scl_p_q;
    wire start = scl & scl_p_q & sda_p_q & ~sda_i;
    wire stop = scl & scl_p_q & ~sda_p_q & sda_i;
    wire full = (cnt_q == 4'h8);

    // Byte engine, acts on clock edges of the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            {scl_p_q, sda_p_q} <= 2'b11;
            {cnt_q, sh_q, ptr_q} <= '0;
            {sda_oe, mack_q, stb_q} <= '0;
        end else begin
            {scl_p_q, sda_p_q} <= {scl, sda_i};
            stb_q <= 1'b0;
            if (start) begin
                st_q <= S_ADDR;
                cnt_q <= '0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                st_q <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (rise) begin
                if (st_q == S_ACKR) begin
                    mack_q <= ~sda_i;
                end else if (st_q == S_ADDR || st_q == S_WR) begin
                    sh_q <= {sh_q[6:0], sda_i};
                end
                cnt_q <= cnt_q + 1'b1;
            end else if (fall) begin
                case (st_q)
                    S_ADDR: if (full) begin
                        st_q <= (sh_q[7:1] == SLAVE_ADDR) ? S_ACKA : S_IDLE;
                        sda_oe <= (sh_q[7:1] == SLAVE_ADDR);
                    end
                    S_ACKA, S_ACKR: begin
                        cnt_q <= '0;
                        if ((st_q == S_ACKA && sh_q[0]) || (st_q == S_ACKR && mack_q)) begin
                            st_q <= S_RD;
                            sh_q <= rif.rdata;
                            stb_q <= 1'b1;
                            sda_oe <= ~rif.rdata[7];
                        end else begin
                            st_q <= (st_q == S_ACKA) ? S_WR : S_IDLE;
                            sda_oe <= 1'b0;
                        end
                    end
                    S_WR: if (full) begin
                        ptr_q <= sh_q;
                        st_q <= S_ACKW;
                        sda_oe <= 1'b1;
                    end
                    S_ACKW: begin
                        st_q <= S_WR;
                        cnt_q <= '0;
                        sda_oe <= 1'b0;
                    end
                    S_RD: begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe <= full ? 1'b0 : ~sh_q[6];
                        if (full) begin
                            st_q <= S_ACKR;
                        end
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    assign sda_o = 1'b0;
    assign rif.ptr = ptr_q;
    assign rif.rd_stb = stb_q;
endmodule : lsfs_i2c
`default_nettype wire

/* rtl/lsfs_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: Over-temperature shuts down, sets status bit 1
// RULE2: Over-temperature bit clears after read, condition gone
// RULE3: Resume automatically when temperature falls back
// RULE4: Temperature warning sets status bit 0
// RULE5: Warning bit clears after read with warning low
// RULE6: Faults pull fault output low, extended hold; short latch-offs (short_q) do not drive the fault output
// RULE7: Open string latches off at overvoltage supply
// RULE8: After open latch, halt until drains, limit low
// RULE9: Short detection masked while active string reads open
// RULE10: Drain above short level cuts current reference
// RULE11: Latched strings release only on enable/power cycle
// RULE12: Grounded gate string is unused, never latched
// RULE13: Broken PWM line reported open at start-up
// RULE14: Over two active, regulated: short turns off
// RULE15: Single active string latches off on short
// RULE16: Short detection blanked after each PWM start
// RULE17: String current follows its own PWM input
// RULE18: Overvoltage limit stops, then resumes switching
// RULE19: Power-on clear releases after delay from rail
// RULE20: Overcurrent sets bit 2, clears after read
// RULE21: Per-string open and overvoltage bits stay latched
// RULE22: Overcurrent-shutdown bit clears after read and restart
module lsfs_top #(
    parameter int HOLD_CYC = lsfs_pkg::HOLD_CYC,
    parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic rail_ok,
    input wire logic ot_shdn,
    input wire logic ot_warn,
    input wire logic overcurrent_event,
    input wire logic overcurrent_shutdown,
    input wire logic [lsfs_pkg::NSTR-1:0] pwm_in,
    input wire logic [lsfs_pkg::NSTR-1:0] pwm_broken,
    input wire logic [lsfs_pkg::NSTR-1:0] drain_open,
    input wire logic [lsfs_pkg::NSTR-1:0] drain_ov,
    input wire logic [lsfs_pkg::NSTR-1:0] drain_short,
    input wire logic [lsfs_pkg::NSTR-1:0] gate_grounded,
    input wire logic led_at_ovp,
    input wire logic ovp_high,
    input wire logic drain_max_hi,
    input wire logic drain_low_ok,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic fault_output_n_o,
    output logic fault_output_n_oe,
    output logic converter_run,
    output logic [lsfs_pkg::NSTR-1:0] string_en,
    output logic [lsfs_pkg::NSTR-1:0] loop_include,
    output logic [lsfs_pkg::NSTR-1:0] cur_reduce
);
    import lsfs_pkg::*;

    if (HOLD_CYC < 9) begin : g_chk
        $error("lsfs_top: HOLD_CYC must be at least 9");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Number of set bits in a string vector
    function automatic logic [2:0] ones(input logic [NSTR-1:0] v);
        logic [2:0] n;
        n = '0;
        for (int i = 0; i < NSTR; i++) begin
            n = n + {2'b00, v[i]};
        end
        return n;
    endfunction : ones

    // Status byte for strings b and b+1
    function automatic logic [7:0] pair(input logic [NSTR-1:0] u, input logic [NSTR-1:0] o,
                                        input logic [NSTR-1:0] v, input int b);
        logic [7:0] r;
        r = STAT_RST;
        for (int k = 0; k < 2; k++) begin
            r[SB_UNUSED + k * SB_STRIDE] = u[b + k];
            r[SB_OPEN + k * SB_STRIDE] = o[b + k];
            r[SB_OV + k * SB_STRIDE] = v[b + k];
        end
        return r;
    endfunction : pair

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s_q, rst_n_q; // Two-stage release of nrst

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {rst_n_q, rst_s_q} <= 2'b00;
        end else begin
            {rst_n_q, rst_s_q} <= {rst_s_q, 1'b1};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    // ----------------------------------------
    // Power-on clear
    // ----------------------------------------
    logic [11:0] por_cnt_q; // Cycles since rail ready
    logic por_done_q;       // Power-on clear released
    wire powered = en & rail_ok;
    wire por_end = powered & ~por_done_q & (por_cnt_q == 12'(POR_CYC - 1));

    // Count from rail ready; enable low restarts the sequence
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end else if (!powered) begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end else if (por_end) begin // see RULE19
            por_done_q <= 1'b1;
        end else if (!por_done_q) begin
            por_cnt_q <= por_cnt_q + 1'b1;
        end
    end

    sequence s_pwr_up;
        !powered ##1 powered;
    endsequence
    property p_por;
        s_pwr_up |-> !por_done_q [*8];
    endproperty
    a_por: assert property (p_por) else $error("clear released too early"); // see RULE19

    // ----------------------------------------
    // String supervision
    // ----------------------------------------
    logic [NSTR-1:0] open_q;  // Open latch-off
    logic [NSTR-1:0] short_q; // Short latch-off
    logic [NSTR-1:0] ov_q;    // Drain overvoltage seen
    logic [NSTR-1:0] pwm_p_q; // Previous PWM level
    logic [NSTR-1:0] blank;   // Short detection blanked
    logic halt_q;             // Switching halted after open latch

    wire [NSTR-1:0] unused = gate_grounded; // see RULE12
    wire [NSTR-1:0] off = open_q | short_q;
    wire [NSTR-1:0] active = ~unused & ~off;
    wire [2:0] n_act = ones(active);
    wire mask = |(active & drain_open); // see RULE9
    // Short allowed: many regulated strings, or the last one
    wire short_arm = ~mask & ((n_act > 3'd2 && drain_low_ok) || n_act == 3'd1); // see RULE14
    wire [NSTR-1:0] short_set = drain_short & active & ~blank & {NSTR{short_arm}}; // see RULE15
    wire [NSTR-1:0] open_set = active & drain_open & {NSTR{led_at_ovp}}; // see RULE7
    wire [NSTR-1:0] pwm_bad = pwm_broken & ~unused & {NSTR{por_end}}; // see RULE13

    // Blanking after each PWM rising edge
    for (genvar gi = 0; gi < NSTR; gi++) begin : g_blank
        lsfs_tmr #(.CYC(BLANK_CYC)) u_blank (
            .clk(clk),
            .rst_n(rst_n_q),
            .load(pwm_in[gi] & ~pwm_p_q[gi]), // see RULE16
            .busy(blank[gi])
        );
    end

    // Latches hold until enable drops or power resets
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            {open_q, short_q, ov_q, pwm_p_q} <= '0;
            halt_q <= 1'b0;
        end else if (!en) begin // see RULE11
            {open_q, short_q, ov_q} <= '0;
            pwm_p_q <= pwm_in;
            halt_q <= 1'b0;
        end else begin
            pwm_p_q <= pwm_in;
            open_q <= open_q | open_set | pwm_bad; // see RULE21
            short_q <= short_q | short_set;
            ov_q <= ov_q | (drain_ov & ~unused); // see RULE12
            // Set wins; release needs drains and limit pin low
            halt_q <= (|open_set) | (halt_q & (drain_max_hi | ovp_high)); // see RULE8
        end
    end

    property p_latch_keep;
        en |=> ((off & $past(off)) == $past(off));
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latched string released"); // see RULE11

    property p_halt;
        |open_set |=> halt_q ##1 (halt_q || (!$past(drain_max_hi) && !$past(ovp_high)));
    endproperty
    a_halt: assert property (p_halt) else $error("halt not held after open latch"); // see RULE8

    property p_unused;
        unused[0] && !ov_q[0] |=> !ov_q[0] && !off[0];
    endproperty
    a_unused: assert property (p_unused) else $error("unused string flagged"); // see RULE12

    // ----------------------------------------
    // Chip fault status
    // ----------------------------------------
    logic [3:0] cf_q; // Chip fault bits
    logic ocs_rd_q;   // Shutdown bit has been read
    logic rd_chip;    // Read of chip status register
    lsfs_reg_if rif ();

    assign rd_chip = rif.rd_stb & (rif.ptr == OFS_CHIP);

    // Live conditions set; a read clears only once the live one is gone
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cf_q <= STAT_RST[3:0];
            ocs_rd_q <= 1'b0;
        end else begin
            cf_q[CB_WARN] <= ot_warn | (cf_q[CB_WARN] & ~rd_chip); // see RULE4
            cf_q[CB_OTP] <= ot_shdn | (cf_q[CB_OTP] & ~rd_chip); // see RULE1
            cf_q[CB_OC] <= overcurrent_event | (cf_q[CB_OC] & ~rd_chip); // see RULE20
            // Shutdown bit waits for read and the restart
            cf_q[CB_OCS] <= overcurrent_shutdown | (cf_q[CB_OCS] & ~ocs_rd_q); // see RULE22
            ocs_rd_q <= cf_q[CB_OCS] & (ocs_rd_q | rd_chip);
        end
    end

    property p_otp;
        ot_shdn |=> cf_q[CB_OTP] && !converter_run;
    endproperty
    a_otp: assert property (p_otp) else $error("over-temperature not latched"); // see RULE1

    property p_otp_keep;
        cf_q[CB_OTP] && !rd_chip |=> cf_q[CB_OTP];
    endproperty
    a_otp_keep: assert property (p_otp_keep) else $error("over-temperature bit lost"); // see RULE2

    property p_warn;
        ot_warn |=> cf_q[CB_WARN];
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit not set"); // see RULE4

    property p_warn_clr;
        cf_q[CB_WARN] && rd_chip && !ot_warn |=> !cf_q[CB_WARN];
    endproperty
    a_warn_clr: assert property (p_warn_clr) else $error("warning bit not cleared"); // see RULE5

    // ----------------------------------------
    // Register read data
    // ----------------------------------------
    assign rif.rdata = (rif.ptr == OFS_STR_LO) ? pair(unused, open_q, ov_q, 0) :
                       (rif.ptr == OFS_STR_HI) ? pair(unused, open_q, ov_q, 2) :
                       (rif.ptr == OFS_CHIP) ? {4'h0, cf_q} : STAT_RST;

    lsfs_i2c #(.SLAVE_ADDR(SLAVE_ADDR)) u_i2c (
        .clk(clk),
        .rst_n(rst_n_q),
        .scl(scl),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .rif(rif)
    );

    // ----------------------------------------
    // Fault output with hold
    // ----------------------------------------
    logic hold; // Hold after last fault
    wire fault_any = (|cf_q) | (|open_q) | (|ov_q);

    lsfs_tmr #(.CYC(HOLD_CYC)) u_hold (
        .clk(clk),
        .rst_n(rst_n_q),
        .load(fault_any),
        .busy(hold)
    );

    // ----------------------------------------
    // Converter and string drive
    // ----------------------------------------
    wire run_d = powered & por_done_q & ~ot_shdn & ~ovp_high & ~halt_q // see RULE18
                 & ~overcurrent_shutdown & (|(pwm_in & active)); // see RULE3
    wire [NSTR-1:0] en_d = pwm_in & active & {NSTR{powered & por_done_q & ~ot_shdn}}; // see RULE17

    // Converter, string and fault outputs registered
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            converter_run <= 1'b0;
            {string_en, loop_include, cur_reduce} <= '0;
            fault_output_n_o <= 1'b0;
            fault_output_n_oe <= 1'b0;
        end else begin
            converter_run <= run_d;
            string_en <= en_d;
            loop_include <= active; // see RULE7
            cur_reduce <= drain_short & ~unused; // see RULE10
            fault_output_n_o <= 1'b0;
            fault_output_n_oe <= fault_any | hold; // see RULE6
        end
    end

    property p_fault_hold;
        $fell(fault_any) |=> fault_output_n_oe [*8];
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault output released early"); // see RULE6

    property p_ovp;
        ovp_high |=> !converter_run;
    endproperty
    a_ovp: assert property (p_ovp) else $error("switching under overvoltage"); // see RULE18

    property p_pwm;
        1'b1 |=> ((string_en & ~$past(pwm_in)) == '0);
    endproperty
    a_pwm: assert property (p_pwm) else $error("string driven with PWM low"); // see RULE17

    property p_reduce;
        drain_short[0] && !unused[0] |=> cur_reduce[0];
    endproperty
    a_reduce: assert property (p_reduce) else $error("current not reduced"); // see RULE10
endmodule : lsfs_top
`default_nettype wire

/* bench/lsfs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the two-wire link: a master that reads status registers
module lsfs_host_model #(
    parameter logic [6:0] ADDR = 7'h2a // Arbitrary value, matches the slave
) (
    input wire logic clk,
    input wire logic sda, // Resolved line level, pulled up
    output logic scl,
    output logic sda_low // High while this master pulls the line low
);
    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    // One third of a bit, slow enough for the synchronous sampler
    task automatic half;
        repeat (8) @(posedge clk);
    endtask : half
    // Start or repeated start: data falls while clock high
    task automatic start;
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask : start
    // Data changes only with the clock low
    task automatic put_bit(input logic b);
        sda_low <= ~b;
        half();
        scl <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask : put_bit
    // Release the line and sample it on the high phase
    task automatic get_bit(output logic b);
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        b = sda;
        scl <= 1'b0;
        half();
    endtask : get_bit
    // Byte out, then the slave acknowledge
    task automatic put_byte(input logic [7:0] v, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(a);
        ok = ok & ~a;
    endtask : put_byte
    // Pointer write, repeated start, one byte read ended by NACK and stop
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        put_byte({ADDR, 1'b0}, ok);
        put_byte(ptr, ok);
        start();
        put_byte({ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask : read_reg
    // Idle bus at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
endmodule : lsfs_host_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import lsfs_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, nrst, en, rail_ok, ocs, ovp_high, scl, sda_low, sda_o, sda_oe, flt_o, flt_oe, run;
    logic [2:0] chip_in; // Warning, over-temperature, overcurrent
    logic at_ovp, d_max_hi, d_low_ok; // Open and regulation sense inputs
    logic [NSTR-1:0] pwm_in, pwm_broken, drain_ov, drain_short, gate_grounded, d_open;
    logic [NSTR-1:0] string_en, loop_include, cur_reduce, m, m2, m3;
    wire logic sda = ~(sda_low | (sda_oe & ~sda_o)); // Open-drain line with pull-up
    int num_errors, n_tests, seed, k;
    logic [31:0] r;
    // ----------------------------------------
    // Design and host
    // ----------------------------------------
    lsfs_top #(.HOLD_CYC(16)) i_lsfs_top (.clk(clk), .nrst(nrst), .en(en), .rail_ok(rail_ok),
        .ot_shdn(chip_in[1]), .ot_warn(chip_in[0]), .overcurrent_event(chip_in[2]),
        .overcurrent_shutdown(ocs), .pwm_in(pwm_in), .pwm_broken(pwm_broken), .drain_open(d_open),
        .drain_ov(drain_ov), .drain_short(drain_short), .gate_grounded(gate_grounded),
        .led_at_ovp(at_ovp), .ovp_high(ovp_high), .drain_max_hi(d_max_hi), .drain_low_ok(d_low_ok),
        .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .fault_output_n_o(flt_o),
        .fault_output_n_oe(flt_oe), .converter_run(run), .string_en(string_en),
        .loop_include(loop_include), .cur_reduce(cur_reduce));
    lsfs_host_model i_lsfs_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Expected string status byte for one pair of strings
    function automatic logic [7:0] exp_pair(logic [3:0] opn, logic [3:0] ov, logic [3:0] unu, int hi);
        logic [7:0] v;
        v = STAT_RST;
        for (int s = 0; s < 2; s++) begin
            v[s*SB_STRIDE+SB_UNUSED] = unu[hi*2+s];
            v[s*SB_STRIDE+SB_OPEN] = opn[hi*2+s];
            v[s*SB_STRIDE+SB_OV] = ov[hi*2+s];
        end
        return v;
    endfunction : exp_pair
    // Register read through the host, then compare
    task automatic rd(input logic [7:0] ptr, input logic [7:0] e, input string nm);
        logic [7:0] got;
        logic ok;
        i_lsfs_host_model.read_reg(ptr, got, ok);
        `CHK("bus_ack", 1'b1, ok)
        `CHK(nm, e, got)
    endtask : rd
    task automatic done(input string nm);
        $display("test %s done, errors %0d", nm, num_errors);
    endtask : done
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        seed = 32'h902d;
        {nrst, en, rail_ok, ocs, ovp_high, chip_in, at_ovp, d_max_hi, d_low_ok} = '0;
        {pwm_broken, drain_ov, drain_short, gate_grounded, d_open} = '0;
        pwm_in = '1;
        repeat (3) @(posedge clk);
        `CHK("run_in_reset", 1'b0, run)
        nrst <= 1'b1;
        en <= 1'b1;
        rail_ok <= 1'b1;
        repeat (POR_CYC + 20) @(posedge clk);
        // Warning, over-temperature and overcurrent bits: latched, held by a read while live, cleared after
        for (int i = 0; i < 3; i++) begin
            chip_in <= 3'b001 << i;
            repeat (4) @(posedge clk);
            `CHK("fault_pin", 1'b1, flt_oe)
            if (i == 1) `CHK("run_otp", 1'b0, run)
            rd(OFS_CHIP, 8'h01 << i, "chip_live");
            chip_in <= 3'b000;
            repeat (4) @(posedge clk);
            if (i == 1) `CHK("run_resume", 1'b1, run)
            rd(OFS_CHIP, 8'h01 << i, "chip_held");
            rd(OFS_CHIP, 8'h00, "chip_clear");
            `CHK("fault_off", 1'b0, flt_oe)
        end
        done("chip status");
        // Shutdown bit survives until read after restart
        ocs <= 1'b1;
        repeat (4) @(posedge clk);
        ocs <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("fault_held", 1'b1, flt_oe)
        `CHK("fault_level", 1'b0, flt_o)
        rd(OFS_CHIP, 8'h08, "ocs_set");
        rd(OFS_CHIP, 8'h00, "ocs_clear");
        // Overvoltage limit stops and resumes switching
        ovp_high <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("run_ovp", 1'b0, run)
        ovp_high <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("run_back", 1'b1, run)
        done("shutdown and limit");
        // Random dimming and one hot drain per round
        for (int j = 0; j < 8; j++) begin
            r = $random(seed);
            k = r[5:4];
            pwm_in <= r[3:0];
            drain_short <= 4'h1 << k;
            repeat (3) @(posedge clk);
            `CHK("string_en", r[3:0], string_en)
            `CHK("cur_reduce", 4'h1 << k, cur_reduce)
            drain_short <= '0;
            repeat (3) @(posedge clk);
            `CHK("cur_normal", 4'h0, cur_reduce)
        end
        pwm_in <= '1;
        done("dimming");
        // High drains on every string, one string unused
        r = $random(seed);
        m = 4'h1 << r[1:0];
        gate_grounded <= m;
        drain_ov <= '1;
        repeat (3) @(posedge clk);
        drain_ov <= '0;
        repeat (3) @(posedge clk);
        rd(OFS_STR_LO, exp_pair(4'h0, ~m, m, 0), "pair_lo_ov");
        rd(OFS_STR_HI, exp_pair(4'h0, ~m, m, 1), "pair_hi_ov");
        done("overvoltage latch");
        // Enable cycle releases latches; broken dimming line found at start-up
        en <= 1'b0;
        repeat (4) @(posedge clk);
        r = $random(seed);
        m = 4'h1 << r[1:0];
        gate_grounded <= '0;
        pwm_broken <= m;
        en <= 1'b1;
        repeat (POR_CYC + 20) @(posedge clk);
        pwm_broken <= '0;
        repeat (3) @(posedge clk);
        `CHK("string_off", ~m, string_en)
        `CHK("loop_out", ~m, loop_include)
        rd(OFS_STR_LO, exp_pair(m, 4'h0, 4'h0, 0), "pair_lo_open");
        rd(OFS_STR_HI, exp_pair(m, 4'h0, 4'h0, 1), "pair_hi_open");
        done("enable cycle");
        // Open string masks shorts, then latches and halts
        m2 = {m[2:0], m[3]};
        m3 = {m2[2:0], m2[3]};
        {d_low_ok, d_open, drain_short} <= {1'b1, m2, m3};
        repeat (3) @(posedge clk);
        `CHK("short_masked", ~m, loop_include)
        d_open <= '0;
        repeat (3) @(posedge clk);
        `CHK("short_off", ~(m | m3), loop_include)
        {at_ovp, d_max_hi, d_open} <= {2'b11, m2};
        repeat (3) @(posedge clk);
        `CHK("open_off", ~(m | m2 | m3), loop_include)
        `CHK("run_halt", 1'b0, run)
        {at_ovp, d_max_hi, d_open} <= '0;
        repeat (3) @(posedge clk);
        `CHK("run_free", 1'b1, run)
        done("open and short");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
